/* pxc2_pkg.sv */
// package: register map, field layout and types for extended control two
package pxc2_pkg;

  // register address within the management frame space
  localparam logic [4:0]  EXT_CTRL_TWO_ADDR = 5'h13;

  // field positions
  localparam int NODE_REP_BIT = 15;
  localparam int HW_SW_BIT    = 14;
  localparam int RFAULT_BIT   = 13;
  localparam int TX_HIZ_BIT   = 7;
  localparam int AUTO_PD_BIT  = 0;

  // writable storage: reserved rw bits, tri-state bit, auto power-down bit
  localparam logic [15:0] WRITE_MASK  = 16'h1BFF;
  localparam logic [15:0] RESET_VALUE = 16'h0001;

  // one management access toward this register
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pxc2_req_type;

  // link status inputs relevant to this register
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic tx_active;
    logic rx_active;
    logic remote_fault;
  } pxc2_link_type;

endpackage

/* pxc2_ext_ctrl.sv */
// module: extended control two register and the controls it steers
// Contract
// - bit 15 reads node (0) or repeater (1) pin strap, also in software configuration, read-only
// - bit 14 reads hardware (0) or software (1) configuration, read-only
// - bits 15 and 14 take the configuration pin levels sampled at reset
// - in software configuration, operating setup comes from register bits
// - node operation defaults to signal quality error test enabled
// - node operation asserts carrier sense on transmit or receive activity
// - bit 13 mirrors the partner's received remote fault indication
// - bit 13 always equals the partner ability remote fault bit
// - bit 7 set tri-states both twisted-pair transmit outputs; resets 0
// - bit 0 set at 10 Mb/s powers down 100 Mb/s transceiver; resets 1
// - bit 0 clear never powers down the transceiver automatically
// - isolate also powers down the transceiver, independent of bit 0
// - signal quality error test suppressed in full duplex and repeater
`timescale 1ns/1ns
module pxc2_ext_ctrl
  import pxc2_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // configuration pins, asynchronous
  input  wire logic          node_repeater_select,
  input  wire logic          hw_sw_select,
  // software configuration from other management registers
  input  wire logic          sw_repeater,
  input  wire logic          sq_test_inhibit,
  input  wire logic          isolate,
  // management access, same clock
  input  wire pxc2_req_type  req,
  output logic               rd_valid,
  output logic [15:0]        rd_data,
  // link status, same clock
  input  wire pxc2_link_type link,
  // controls to transceiver and mac
  output logic               tx_pair_hiz_enable,
  output logic               tx_pair_positive_oe,
  output logic               tx_pair_negative_oe,
  output logic               tx100_power_down,
  output logic               signal_quality_error_test,
  output logic               carrier_sense
);

  // pin synchronisers; first stage read only by second stage
  logic       nr_meta;
  logic       nr_sync;
  logic       hs_meta;
  logic       hs_sync;
  logic       rst_d;
  logic       strap_node_rep;
  logic       strap_hw_sw;
  logic [15:0] stored;

  always_ff @(posedge clk)
  begin
    nr_meta <= node_repeater_select;
    nr_sync <= nr_meta;
    hs_meta <= hw_sw_select;
    hs_sync <= hs_meta;
  end

  // straps caught on the first edge after reset release
  always_ff @(posedge clk)
  begin
    rst_d <= rst;
    if (rst_d && !rst)
    begin
      strap_node_rep <= nr_sync;
      strap_hw_sw    <= hs_sync;
    end
  end

  // decode of management access
  wire hit      = req.valid && (req.addr == EXT_CTRL_TWO_ADDR);
  wire wr_hit   = hit && req.write;
  wire rd_hit   = hit && !req.write;
  // reserved bits keep what was written; station owes zeros there
  wire [15:0] next_stored = (stored & ~WRITE_MASK)
                          | (req.wdata & WRITE_MASK);

  // writable bits; read-only bits never stored
  always_ff @(posedge clk)
  begin
    if (rst)
      stored <= RESET_VALUE;
    else if (wr_hit)
      stored <= next_stored;
  end

  // effective mode: software config overrides pins
  wire repeater = strap_hw_sw ? sw_repeater : strap_node_rep;
  wire node     = !repeater;

  // read word assembly
  wire [15:0] read_word = {strap_node_rep,
                           strap_hw_sw,
                           link.remote_fault,
                           stored[12:0]};

  wire next_pd  = (stored[AUTO_PD_BIT] && !link.speed_100)
                || isolate;
  // inhibit and duplex only ever take the test away, never grant it
  wire next_sq_test = node && !sq_test_inhibit
                    && !link.full_duplex;
  wire next_crs = node ? (link.tx_active || link.rx_active)
                       : link.rx_active;

  // answer and control outputs, all registered
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_valid                  <= 1'b0;
      rd_data                   <= 16'h0000;
      tx_pair_hiz_enable        <= 1'b0;
      tx_pair_positive_oe       <= 1'b0;
      tx_pair_negative_oe       <= 1'b0;
      tx100_power_down          <= 1'b0;
      signal_quality_error_test <= 1'b0;
      carrier_sense             <= 1'b0;
    end
    else
    begin
      rd_valid                  <= rd_hit;
      rd_data                   <= rd_hit ? read_word : 16'h0000;
      tx_pair_hiz_enable        <= stored[TX_HIZ_BIT];
      tx_pair_positive_oe       <= !stored[TX_HIZ_BIT];
      tx_pair_negative_oe       <= !stored[TX_HIZ_BIT];
      tx100_power_down          <= next_pd;
      signal_quality_error_test <= next_sq_test;
      carrier_sense             <= next_crs;
    end
  end

  // tri-state follows bit 7 one cycle later
  // skipped on the edge after reset, where outputs still hold reset zeros
  tri_state_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> tx_pair_positive_oe == !$past(stored[TX_HIZ_BIT]))
    else $error("tx pair enable does not follow bit 7");

  // read answer carries live remote fault
  rfault_read_a: assert property (@(posedge clk) disable iff (rst)
    rd_hit |=> rd_valid && rd_data[RFAULT_BIT] == $past(link.remote_fault))
    else $error("remote fault read mismatch");

  // strap bits on read
  strap_read_a: assert property (@(posedge clk) disable iff (rst)
    rd_hit |=> rd_data[NODE_REP_BIT] == strap_node_rep
           && rd_data[HW_SW_BIT] == strap_hw_sw)
    else $error("strap bits read wrong");

  // write cannot touch read-only bits
  ro_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_hit |=> stored[15:13] == 3'b000 && !stored[10])
    else $error("read-only bits changed by write");

  // power down when auto set at ten; rst in antecedent skips release edge
  auto_pd_a: assert property (@(posedge clk) disable iff (rst)
    (!rst && stored[AUTO_PD_BIT] && !link.speed_100) |=> tx100_power_down)
    else $error("auto power down missing");

  // no power down without cause
  no_pd_a: assert property (@(posedge clk) disable iff (rst)
    (!stored[AUTO_PD_BIT] && !isolate) |=> !tx100_power_down)
    else $error("power down without cause");

  // isolate powers down
  isolate_pd_a: assert property (@(posedge clk) disable iff (rst)
    (!rst && isolate) |=> tx100_power_down)
    else $error("isolate did not power down");

  // quality test suppressed in full duplex and repeater
  sq_fdx_a: assert property (@(posedge clk) disable iff (rst)
    (link.full_duplex || repeater) |=> !signal_quality_error_test)
    else $error("quality test not suppressed");

  // node carrier sense on transmit
  crs_tx_a: assert property (@(posedge clk) disable iff (rst)
    (!rst && node && link.tx_active) |=> carrier_sense)
    else $error("carrier sense missing on transmit");

  // tri-state flag tracks bit 7 directly
  hiz_follow_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> tx_pair_hiz_enable == $past(stored[TX_HIZ_BIT]))
    else $error("tri-state flag does not follow bit 7");

  // negative leg enable follows bit 7 as well
  neg_oe_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> tx_pair_negative_oe == !$past(stored[TX_HIZ_BIT]))
    else $error("negative leg enable does not follow bit 7");

  // both legs always switch together
  oe_pair_a: assert property (@(posedge clk) disable iff (rst)
    tx_pair_positive_oe == tx_pair_negative_oe)
    else $error("transmit legs disagree");

  // never driving while tri-state is requested
  hiz_excl_a: assert property (@(posedge clk) disable iff (rst)
    !(tx_pair_hiz_enable && tx_pair_positive_oe))
    else $error("driving while tri-stated");

  // tri-state bit comes out of reset clear
  reset_hiz_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> !stored[TX_HIZ_BIT])
    else $error("tri-state bit not clear after reset");

  // auto power-down bit comes out of reset set
  reset_pd_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> stored[AUTO_PD_BIT])
    else $error("auto power-down bit not set after reset");

  // other addresses get no answer
  rd_other_a: assert property (@(posedge clk) disable iff (rst)
    (!rst && req.valid && req.addr != EXT_CTRL_TWO_ADDR) |=> !rd_valid)
    else $error("answer to foreign address");

  // a write is never answered with read data
  wr_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (!rst && wr_hit) |=> !rd_valid)
    else $error("write produced a read answer");

  // read data is zero outside the answer cycle
  rd_idle_a: assert property (@(posedge clk) disable iff (rst)
    !rd_valid |-> rd_data == 16'h0000)
    else $error("read data not idle");

  // read request and its answer, one cycle apart
  sequence read_req_s;
    !rst && rd_hit;
  endsequence

  sequence read_ans_s;
    rd_valid && rd_data[12:0] == $past(stored[12:0]);
  endsequence

  // answer carries the stored low bits
  rd_word_a: assert property (@(posedge clk) disable iff (rst)
    read_req_s |=> read_ans_s)
    else $error("read answer missing or wrong");

  // reserved read-only bit reads zero
  rd_bit10_a: assert property (@(posedge clk) disable iff (rst)
    read_req_s |=> !rd_data[10])
    else $error("reserved read-only bit not zero");

  // write lands in the tri-state bit
  wr_hiz_a: assert property (@(posedge clk) disable iff (rst)
    wr_hit |=> stored[TX_HIZ_BIT] == $past(req.wdata[TX_HIZ_BIT]))
    else $error("tri-state bit write lost");

  // write lands in the auto power-down bit
  wr_pd_a: assert property (@(posedge clk) disable iff (rst)
    wr_hit |=> stored[AUTO_PD_BIT] == $past(req.wdata[AUTO_PD_BIT]))
    else $error("auto power-down bit write lost");

  // storage holds without a write
  no_wr_hold_a: assert property (@(posedge clk) disable iff (rst)
    (!rst && !wr_hit) |=> $stable(stored))
    else $error("register changed without write");

  // no automatic power down at 100 without isolate
  pd_at_100_a: assert property (@(posedge clk) disable iff (rst)
    (!rst && !isolate && link.speed_100) |=> !tx100_power_down)
    else $error("power down at 100 Mb/s");

  // node default grants the quality test
  sq_node_a: assert property (@(posedge clk) disable iff (rst)
    (!rst && node && !sq_test_inhibit && !link.full_duplex)
      |=> signal_quality_error_test)
    else $error("quality test missing in node");

  // inhibit control takes the test away
  sq_inhibit_a: assert property (@(posedge clk) disable iff (rst)
    sq_test_inhibit |=> !signal_quality_error_test)
    else $error("quality test not inhibited");

  // receive activity always raises carrier sense
  crs_rx_a: assert property (@(posedge clk) disable iff (rst)
    (!rst && link.rx_active) |=> carrier_sense)
    else $error("carrier sense missing on receive");

  // no activity, no carrier sense
  crs_idle_a: assert property (@(posedge clk) disable iff (rst)
    (!link.tx_active && !link.rx_active) |=> !carrier_sense)
    else $error("carrier sense without activity");

  // repeater ignores own transmit for carrier sense
  crs_rep_a: assert property (@(posedge clk) disable iff (rst)
    (!rst && repeater && !link.rx_active) |=> !carrier_sense)
    else $error("repeater carrier sense on transmit");

  // software setup steers the mode when bit 14 is set
  mode_sw_a: assert property (@(posedge clk) disable iff (rst)
    strap_hw_sw |-> repeater == sw_repeater)
    else $error("software mode not applied");

  // straps move only on reset release
  strap_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(rst_d && !rst) |=> $stable(strap_node_rep) && $stable(strap_hw_sw))
    else $error("strap changed outside reset release");

endmodule // pxc2_ext_ctrl

/* pxc2_sta_model.sv */
// station management model: one-word reads and writes to the phy
`timescale 1ns/1ns
module pxc2_mgmt_model
  import pxc2_pkg::*;
(
  // clock
  input  wire logic        clk,
  // request out, answer back
  output pxc2_req_type     req,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data
);
  initial req = '0;
  // released lines show the inverse, never a stale value
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [15:0] d);
    @(posedge clk) req <= {1'b1, w, a, d};
    @(posedge clk) req <= {1'b0, ~w, ~a, ~d};
  endtask
  // reserved bits always go out as zero
  task automatic wr(input logic [15:0] d);
    xfer(1'b1, EXT_CTRL_TWO_ADDR, d & 16'hE081);
  endtask
  // answer stands one cycle, taken just after the edge
  task automatic rd(input logic [4:0] a, output logic [15:0] q,
                    output logic v);
    xfer(1'b0, a, 16'h0000);
    #1 q = rd_data;
    v = rd_valid;
  endtask
endmodule // pxc2_mgmt_model

/* phy_extended_control_two_tb.sv */
// testbench: extended control two register and its controls
`timescale 1ns/1ns
module phy_extended_control_two_tb;
  import pxc2_pkg::*;
  logic          clk, rst, node_pin, hwsw_pin, sw_rep, inhib, iso, v, rep;
  logic          rdv, hiz, poe, noe, pd, sqt, crs;
  logic [15:0]   rdd, q, w;
  logic [31:0]   r;
  pxc2_req_type  req;
  pxc2_link_type link;
  int            err_total, n_tests, seed, i;
  pxc2_ext_ctrl dut (.clk(clk), .rst(rst), .node_repeater_select(node_pin),
    .hw_sw_select(hwsw_pin), .sw_repeater(sw_rep), .sq_test_inhibit(inhib),
    .isolate(iso), .req(req), .rd_valid(rdv), .rd_data(rdd), .link(link),
    .tx_pair_hiz_enable(hiz), .tx_pair_positive_oe(poe),
    .tx_pair_negative_oe(noe), .tx100_power_down(pd),
    .signal_quality_error_test(sqt), .carrier_sense(crs));
  pxc2_mgmt_model mgmt (.clk(clk), .req(req), .rd_valid(rdv), .rd_data(rdd));
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // straps must be steady while reset is held so the sync settles
  task automatic do_reset(input logic n, h);
    @(posedge clk) rst <= 1'b1;
    node_pin <= n;
    hwsw_pin <= h;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    w = 16'h0001;
    repeat (3) @(posedge clk);
  endtask
  // read back the word, then every steered control
  task automatic check_all();
    mgmt.rd(EXT_CTRL_TWO_ADDR, q, v);
    rep = hwsw_pin ? sw_rep : node_pin;
    chk("rd_valid", {15'h0, v}, 16'h0001);
    chk("word", q, {node_pin, hwsw_pin, link.remote_fault, 5'h0, w[7],
        6'h0, w[0]});
    chk("hiz", {13'h0, hiz, poe, noe}, {13'h0, w[7], !w[7], !w[7]});
    chk("pd", {15'h0, pd}, {15'h0, iso | (w[0] & !link.speed_100)});
    chk("sq_test", {15'h0, sqt}, {15'h0, !rep & !inhib & !link.full_duplex});
    chk("crs", {15'h0, crs}, {15'h0, rep ? link.rx_active
        : link.tx_active | link.rx_active});
  endtask
  initial
  begin
    seed = 14451;
    err_total = 0;
    n_tests = 0;
    rst = 1'b1;
    {node_pin, hwsw_pin, sw_rep, inhib, iso} = 5'b01000;
    link = '0;
    do_reset(1'b0, 1'b1);
    check_all();
    mgmt.wr(16'hFFFF); // read-only bits must not move
    w = 16'h0081;
    check_all();
    mgmt.rd(5'h12, q, v);
    chk("other addr", {15'h0, v}, 16'h0000);
    for (i = 0; i < 40; i++)
    begin
      if (i == 20)
        do_reset(1'b1, 1'b0);
      r = $random(seed);
      @(posedge clk) {sw_rep, inhib, iso, link} <= r[7:0];
      w = r[23:8] & 16'h0081;
      mgmt.wr(w);
      check_all();
    end
    wrap_up();
  end
  // hang guard, far beyond the expected run
  initial
  begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule // phy_extended_control_two_tb
